// [hw/fdcpd_decode.sv]
// Command parameter decoder of the floppy controller core.
// Assumes a command byte parser upstream delivering decoded fields with a
// one-cycle load pulse, and a disk engine reporting sector and byte events,
// all on mclk.
// Function
// - Multi-track joins head 0 and head 1 of a cylinder into one track.
// - Size code 00 means 128-byte sectors, bytes passed set by special length.
// - Nonzero size code N gives 128 shl N bytes, codes up to 07 accepted.
// - Non-DMA flag gives an interrupt per byte, else DMA requests.
// - Perpendicular bits D0-D3 change only while overwrite flag is 1.
// - Sense interrupt status result reports the present cylinder.
// - Polling disable flag stops drive polling, clearing it restarts it.
// - Precompensation start track accepts every value 00 to FF.
// - Sector address is the first sector of a multi-sector transfer.
// - Relative seek moves by the offset from the present cylinder.
// - Seek targets the new cylinder field.
// - Sectors-per-track counts format sectors; verify with count counts special length.
// - Skip flag set makes read data skip deleted-mark sectors.
// - Skip flag set makes read deleted access deleted-mark sectors only.
// - Skip flag clear reads or writes every sector without skipping.
// - Step rate field sets step pulse spacing, 0.5 to 8 ms in 0.5 ms.
// - Four status bytes are held and read back in the result phase.
// - Write gate setting delays data after write enable for pre-erase.
// - Enable-count bit turns verify special length into sectors count.
`timescale 1ns/1ps

module fdcpd_decode #(
  parameter int STEP_UNIT_CYC =
    fdcpd_pkg::STEP_UNIT_NS / fdcpd_pkg::CLK_PERIOD_NS,
  parameter int PREERASE_CYC = fdcpd_pkg::PREERASE_CYC_MIN
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic cmdLoad,
  input wire logic [3:0] cmdOp,
  input wire logic multiTrackFlag,
  input wire logic skipFlag,
  input wire logic nonDmaFlag,
  input wire logic [7:0] sizeCode,
  input wire logic [7:0] sectorAddr,
  input wire logic headAddr,
  input wire logic [7:0] specialSectorLength,
  input wire logic [7:0] sectorsPerTrackField,
  input wire logic enableCountBit,
  input wire logic [7:0] newCylinderField,
  input wire logic [7:0] relativeCylinderOffset,
  input wire logic stepInward,
  input wire logic [3:0] stepRateField,
  input wire logic overwriteFlag,
  input wire logic [3:0] perpDriveBits,
  input wire logic pollingDisable,
  input wire logic [7:0] precompStartTrack,
  input wire logic writeGateSetting,
  input wire logic sectorDone,
  input wire logic sectorDeleted,
  input wire logic endOfTrack,
  input wire logic byteXfer,
  input wire logic writeGateReq,
  input wire logic statusLoad,
  input wire logic [7:0] statusRegZero,
  input wire logic [7:0] statusRegOne,
  input wire logic [7:0] statusRegTwo,
  input wire logic [7:0] statusRegThree,
  input wire logic resultRead,
  output logic cmdReject,
  output logic xferActive,
  output logic seekActive,
  output logic resultPhase,
  output logic opDone,
  output logic [7:0] curSector,
  output logic curHead,
  output logic [14:0] sectorBytes,
  output logic [14:0] hostBytes,
  output logic sectorPass,
  output logic sectorSkip,
  output logic xferIrq,
  output logic dmaReq,
  output logic [7:0] presentCylinder,
  output logic stepPulse,
  output logic stepDir,
  output logic pollEnable,
  output logic precompActive,
  output logic [3:0] perpDrives,
  output logic writeEnable,
  output logic writeDataOk,
  output logic [7:0] resultByte
);

  // Refuse counts that the step and pre-erase counters cannot hold
  if (STEP_UNIT_CYC < 1 ||
      STEP_UNIT_CYC * fdcpd_pkg::STEP_SLOTS >=
      (1 << fdcpd_pkg::STEP_CNT_W)) begin : g_bad_step
    $error("STEP_UNIT_CYC out of range");
  end
  if (PREERASE_CYC < 1 || PREERASE_CYC > 65535) begin : g_bad_preerase
    $error("PREERASE_CYC out of range");
  end

  // Whole state of the decoder
  typedef struct packed {
    fdcpd_pkg::fdcpd_state_t state;
    fdcpd_pkg::fdcpd_op_t op;
    logic mt;
    logic sk;
    logic nd;
    logic countMode;
    logic [7:0] left;
    logic [7:0] sector;
    logic head;
    logic [14:0] secBytes;
    logic [14:0] hstBytes;
    logic [7:0] target;
    logic [7:0] present_cylinder_field;
    logic dir;
    logic [3:0] step_rate_field;
    logic [fdcpd_pkg::STEP_CNT_W-1:0] stepCnt;
    logic pollEn;
    logic [7:0] precomp_start_track;
    logic precomp;
    logic ow;
    logic [3:0] perp;
    logic write_gate_setting;
    logic [15:0] preCnt;
    logic wrEn;
    logic wrOk;
    logic [3:0][7:0] st;
    logic senseRes;
    logic [1:0] resIdx;
    logic [7:0] resByte;
    logic reject;
    logic done;
    logic pass;
    logic skip;
    logic irq;
    logic dreq;
    logic step;
  } fdcpd_regs_t;

  fdcpd_regs_t r;
  fdcpd_regs_t n;

  // Step spacing from the programmed rate: F is shortest, 0 is longest
  function automatic logic [fdcpd_pkg::STEP_CNT_W-1:0] step_gap(
    input logic [3:0] rate
  );
    step_gap = fdcpd_pkg::STEP_CNT_W'(
      (fdcpd_pkg::STEP_SLOTS - int'(rate)) * STEP_UNIT_CYC);
  endfunction : step_gap

  // Result byte for a slot; sense interrupt puts cylinder in slot one
  function automatic logic [7:0] res_pick(
    input fdcpd_regs_t s,
    input logic [1:0] idx
  );
    if (s.senseRes && idx == fdcpd_pkg::RES_SENSE_LAST) begin
      res_pick = s.present_cylinder_field;
    end else begin
      res_pick = s.st[idx];
    end
  endfunction : res_pick

  logic [8:0] relSum;
  logic [8:0] relDiff;
  logic passNow;

  // Next-state logic
  always_comb begin
    n = r;
    n.done = 1'b0;
    n.pass = 1'b0;
    n.skip = 1'b0;
    n.irq = 1'b0;
    n.dreq = 1'b0;
    n.step = 1'b0;
    n.reject = 1'b0;
    relSum = {1'b0, r.present_cylinder_field} + {1'b0, relativeCylinderOffset};
    relDiff = {1'b0, r.present_cylinder_field} - {1'b0, relativeCylinderOffset};
    passNow = 1'b1;

    // Polling follows the flag at every cycle
    n.pollEn = !pollingDisable;

    // Command load, taken only while idle
    if (cmdLoad && r.state == fdcpd_pkg::ST_IDLE) begin
      case (fdcpd_pkg::fdcpd_op_t'(cmdOp))
        fdcpd_pkg::OP_READ, fdcpd_pkg::OP_READ_DEL, fdcpd_pkg::OP_WRITE,
        fdcpd_pkg::OP_VERIFY, fdcpd_pkg::OP_FORMAT: begin
          if (sizeCode > fdcpd_pkg::MAX_SIZE_CODE) begin
            n.reject = 1'b1;
          end else begin
            n.op = fdcpd_pkg::fdcpd_op_t'(cmdOp);
            n.state = fdcpd_pkg::ST_XFER;
            n.mt = multiTrackFlag;
            n.sk = skipFlag;
            n.nd = nonDmaFlag;
            n.sector = sectorAddr;
            n.head = headAddr;
            n.secBytes = fdcpd_pkg::BASE_SECTOR_BYTES << sizeCode[2:0];
            // Size code 00 passes only the special length to the host
            if (sizeCode == 8'h00) begin
              n.hstBytes = {7'h00, specialSectorLength};
            end else begin
              n.hstBytes = fdcpd_pkg::BASE_SECTOR_BYTES
                           << sizeCode[2:0];
            end
            // Format always counts; verify counts when enabled
            n.countMode = (cmdOp == fdcpd_pkg::OP_FORMAT) ||
                          (cmdOp == fdcpd_pkg::OP_VERIFY &&
                           enableCountBit);
            if (cmdOp == fdcpd_pkg::OP_VERIFY && enableCountBit) begin
              n.left = specialSectorLength;
            end else begin
              n.left = sectorsPerTrackField;
            end
          end
        end
        fdcpd_pkg::OP_SEEK: begin
          n.target = newCylinderField;
          n.state = fdcpd_pkg::ST_SEEK;
          n.step_rate_field = stepRateField;
          n.stepCnt = step_gap(stepRateField);
        end
        fdcpd_pkg::OP_REL_SEEK: begin
          // Saturate at the ends of the cylinder range
          if (stepInward) begin
            n.target = relSum[8] ? fdcpd_pkg::CYL_MAX
                                 : relSum[7:0];
          end else begin
            n.target = relDiff[8] ? fdcpd_pkg::CYL_MIN
                                  : relDiff[7:0];
          end
          n.state = fdcpd_pkg::ST_SEEK;
          n.step_rate_field = stepRateField;
          n.stepCnt = step_gap(stepRateField);
        end
        fdcpd_pkg::OP_SENSE_INT: begin
          n.senseRes = 1'b1;
          n.resIdx = fdcpd_pkg::RES_FIRST;
          n.resByte = r.st[fdcpd_pkg::RES_FIRST];
          n.state = fdcpd_pkg::ST_RESULT;
        end
        fdcpd_pkg::OP_SPECIFY: begin
          n.step_rate_field = stepRateField;
          n.nd = nonDmaFlag;
        end
        fdcpd_pkg::OP_PERP: begin
          n.write_gate_setting = writeGateSetting;
          if (r.ow) begin
            n.perp = perpDriveBits;
          end
        end
        fdcpd_pkg::OP_LOCK: begin
          n.ow = overwriteFlag;
        end
        fdcpd_pkg::OP_CONFIGURE: begin
          n.precomp_start_track = precompStartTrack;
        end
        default: begin
          n.reject = 1'b1;
        end
      endcase
    end else if (cmdLoad) begin
      n.reject = 1'b1;
    end

    case (r.state)
      fdcpd_pkg::ST_XFER: begin
        // Byte handshake: per-byte interrupt or DMA request
        if (byteXfer) begin
          n.irq = r.nd;
          n.dreq = !r.nd;
        end
        if (sectorDone) begin
          // Deleted-mark filtering on reads only
          if (r.sk && r.op == fdcpd_pkg::OP_READ) begin
            passNow = !sectorDeleted;
          end else if (r.sk && r.op == fdcpd_pkg::OP_READ_DEL) begin
            passNow = sectorDeleted;
          end else begin
            passNow = 1'b1;
          end
          n.pass = passNow;
          n.skip = !passNow;
          if (r.countMode) begin
            n.left = r.left - 8'h01;
            n.sector = r.sector + 8'h01;
            if (r.left <= 8'h01) begin
              n.state = fdcpd_pkg::ST_IDLE;
              n.done = 1'b1;
            end
          end else if (endOfTrack) begin
            // Continue onto head 1 when both sides form one track
            if (r.mt && r.head == fdcpd_pkg::HEAD_ZERO) begin
              n.head = fdcpd_pkg::HEAD_ONE;
              n.sector = fdcpd_pkg::FIRST_SECTOR;
            end else begin
              n.state = fdcpd_pkg::ST_IDLE;
              n.done = 1'b1;
            end
          end else begin
            n.sector = r.sector + 8'h01;
          end
        end
      end
      fdcpd_pkg::ST_SEEK: begin
        if (r.present_cylinder_field == r.target) begin
          n.state = fdcpd_pkg::ST_IDLE;
          n.done = 1'b1;
        end else if (r.stepCnt <= fdcpd_pkg::STEP_CNT_W'(1)) begin
          // One step per gap, reloaded from the current rate
          n.step = 1'b1;
          n.dir = r.target > r.present_cylinder_field;
          n.present_cylinder_field = (r.target > r.present_cylinder_field) ? r.present_cylinder_field + 8'h01
                                     : r.present_cylinder_field - 8'h01;
          n.stepCnt = step_gap(r.step_rate_field);
        end else begin
          n.stepCnt = r.stepCnt - fdcpd_pkg::STEP_CNT_W'(1);
        end
      end
      fdcpd_pkg::ST_RESULT: begin
        if (resultRead) begin
          if ((r.senseRes && r.resIdx == fdcpd_pkg::RES_SENSE_LAST) ||
              r.resIdx == fdcpd_pkg::RES_LAST) begin
            n.state = fdcpd_pkg::ST_IDLE;
            n.senseRes = 1'b0;
          end else begin
            n.resIdx = r.resIdx + 2'h1;
            n.resByte = res_pick(r, r.resIdx + 2'h1);
          end
        end
      end
      default: begin
      end
    endcase

    // Engine status capture opens the result phase
    if (statusLoad && r.state != fdcpd_pkg::ST_RESULT) begin
      n.st = {statusRegThree, statusRegTwo, statusRegOne,
              statusRegZero};
      n.senseRes = 1'b0;
      n.resIdx = fdcpd_pkg::RES_FIRST;
      n.resByte = statusRegZero;
      n.state = fdcpd_pkg::ST_RESULT;
    end

    // Write gate: with the setting, data waits out the pre-erase lead
    n.wrEn = writeGateReq;
    if (!writeGateReq) begin
      n.preCnt = 16'h0000;
      n.wrOk = 1'b0;
    end else if (!r.write_gate_setting) begin
      n.wrOk = 1'b1;
    end else if (r.preCnt >= 16'(PREERASE_CYC)) begin
      n.wrOk = 1'b1;
    end else begin
      n.preCnt = r.preCnt + 16'h0001;
    end

    // Threshold registered so the output leaves a flop
    n.precomp = n.present_cylinder_field >= n.precomp_start_track;
  end

  // State register
  always_ff @(posedge mclk) begin
    if (srst) begin
      r <= '0;
      r.state <= fdcpd_pkg::ST_IDLE;
      r.op <= fdcpd_pkg::OP_READ;
      r.secBytes <= fdcpd_pkg::BASE_SECTOR_BYTES;
      r.hstBytes <= fdcpd_pkg::BASE_SECTOR_BYTES;
      r.sector <= fdcpd_pkg::FIRST_SECTOR;
      r.pollEn <= 1'b1;
      r.precomp <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from the state flops
  assign cmdReject = r.reject;
  assign xferActive = r.state[1];
  assign seekActive = r.state[2];
  assign resultPhase = r.state[3];
  assign opDone = r.done;
  assign curSector = r.sector;
  assign curHead = r.head;
  assign sectorBytes = r.secBytes;
  assign hostBytes = r.hstBytes;
  assign sectorPass = r.pass;
  assign sectorSkip = r.skip;
  assign xferIrq = r.irq;
  assign dmaReq = r.dreq;
  assign presentCylinder = r.present_cylinder_field;
  assign stepPulse = r.step;
  assign stepDir = r.dir;
  assign pollEnable = r.pollEn;
  assign precompActive = r.precomp;
  assign perpDrives = r.perp;
  assign writeEnable = r.wrEn;
  assign writeDataOk = r.wrOk;
  assign resultByte = r.resByte;

endmodule : fdcpd_decode

// [hw/fdcpd_pkg.sv]
// Constants and types for the floppy command parameter decoder.
// Assumes one 100 MHz clock shared with the command and execution logic.
package fdcpd_pkg;

  // Clock and timing figures
  localparam int CLK_PERIOD_NS = 10;
  localparam int STEP_UNIT_NS = 500000;  // 0.5 ms step granularity
  localparam int PREERASE_NS = 2000;     // Pre-erase lead of write enable
  localparam int PREERASE_CYC_MIN = (PREERASE_NS + CLK_PERIOD_NS - 1)
                                    / CLK_PERIOD_NS;
  localparam int STEP_SLOTS = 16;        // 16 slots of 0.5 ms: 0.5..8 ms
  localparam int STEP_CNT_W = 24;

  // Sector geometry
  localparam logic [7:0] MAX_SIZE_CODE = 8'h07;
  localparam logic [14:0] BASE_SECTOR_BYTES = 15'h0080;
  localparam logic [7:0] FIRST_SECTOR = 8'h01;
  localparam logic [7:0] CYL_MIN = 8'h00;
  localparam logic [7:0] CYL_MAX = 8'hFF;
  localparam logic HEAD_ZERO = 1'b0;
  localparam logic HEAD_ONE = 1'b1;

  // Result phase byte slots
  localparam logic [1:0] RES_FIRST = 2'h0;
  localparam logic [1:0] RES_SENSE_LAST = 2'h1;
  localparam logic [1:0] RES_LAST = 2'h3;

  // Command classes seen by the decoder
  typedef enum logic [3:0] {
    OP_READ = 4'h0,
    OP_READ_DEL = 4'h1,
    OP_WRITE = 4'h2,
    OP_VERIFY = 4'h3,
    OP_FORMAT = 4'h4,
    OP_SEEK = 4'h5,
    OP_REL_SEEK = 4'h6,
    OP_SENSE_INT = 4'h7,
    OP_SPECIFY = 4'h8,
    OP_PERP = 4'h9,
    OP_LOCK = 4'hA,
    OP_CONFIGURE = 4'hB
  } fdcpd_op_t;

  // Controller phase, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_XFER = 4'h2,
    ST_SEEK = 4'h4,
    ST_RESULT = 4'h8
  } fdcpd_state_t;

endpackage : fdcpd_pkg

// [dv/fdcpd_decode_asserts.sv]
// Concurrent checks on the command parameter decoder ports.
// Assumes mclk as the only clock and srst synchronous, active high.
`timescale 1ns/1ps

module fdcpd_decode_asserts (
  input wire logic mclk,
  input wire logic srst,
  input wire logic xferActive,
  input wire logic seekActive,
  input wire logic resultPhase,
  input wire logic opDone,
  input wire logic byteXfer,
  input wire logic xferIrq,
  input wire logic dmaReq,
  input wire logic sectorDone,
  input wire logic sectorPass,
  input wire logic sectorSkip,
  input wire logic stepPulse,
  input wire logic stepDir,
  input wire logic [7:0] presentCylinder,
  input wire logic pollingDisable,
  input wire logic pollEnable,
  input wire logic writeGateReq,
  input wire logic writeEnable,
  input wire logic writeDataOk,
  input wire logic statusLoad,
  input wire logic [7:0] statusRegZero,
  input wire logic [7:0] resultByte
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  // Level outputs one flop behind their cause, and write data only with write enable
  a_poll_follow: assert property (
    !$past(srst) |-> pollEnable == !$past(pollingDisable))
    else $error("poll enable does not follow disable flag");
  a_wen_delay: assert property (
    !$past(srst) |-> writeEnable == $past(writeGateReq))
    else $error("write enable not one cycle behind request");
  a_data_gated: assert property (
    writeDataOk |-> writeEnable)
    else $error("write data allowed without write enable");

  // Each step moves the cylinder by one in the step direction
  a_step_move: assert property (
    stepPulse && !$past(srst) |-> presentCylinder ==
      $past(presentCylinder) + (stepDir ? 8'h01 : 8'hFF))
    else $error("cylinder not moved by one step");

  // One service request per byte, interrupt or DMA but never both
  a_byte_service: assert property (
    byteXfer && xferActive |=> xferIrq != dmaReq)
    else $error("byte not serviced by exactly one request");
  a_no_stray: assert property (
    xferIrq || dmaReq |-> $past(byteXfer))
    else $error("service request without a byte");

  // Every sector gets exactly one verdict
  a_sector_verdict: assert property (
    sectorDone && xferActive |=> sectorPass != sectorSkip)
    else $error("sector without a single verdict");
  a_done_idle: assert property (
    opDone |-> !xferActive && !seekActive)
    else $error("operation done while still active");

  // Result phase opens on the first status byte
  a_result_first: assert property (
    statusLoad && !resultPhase |=>
      resultPhase && resultByte == $past(statusRegZero))
    else $error("result phase not opened with first status");
endmodule : fdcpd_decode_asserts

bind fdcpd_decode fdcpd_decode_asserts u_fdcpd_decode_asserts (.*);

// [dv/fdcpd_disk_model.sv]
// Disk engine model: one byte and one sector event per six cycles.
// Assumes the decoder's curSector names the sector under the head.
`timescale 1ns/1ps

module fdcpd_disk_model (
  input wire logic mclk,
  input wire logic xferActive,
  input wire logic [7:0] curSector,
  input wire logic [7:0] lastSector,
  input wire logic [7:0] delMask,
  output logic sectorDone,
  output logic sectorDeleted,
  output logic endOfTrack,
  output logic byteXfer
);
  int n = 0;

  initial {sectorDone, sectorDeleted, endOfTrack, byteXfer} = '0;

  // Qualifiers stay low off the sector mark, never stale
  always @(posedge mclk) begin
    #1;
    n = xferActive ? (n + 1) % 6 : 0;
    byteXfer = xferActive && n == 2;
    sectorDone = xferActive && n == 5;
    sectorDeleted = sectorDone && delMask[curSector[2:0]];
    endOfTrack = sectorDone && curSector == lastSector;
  end
endmodule : fdcpd_disk_model

// [dv/tb_fdcpd_decode.sv]
// Testbench for the command parameter decoder with a disk model.
// Assumes shortened step unit and pre-erase counts, set below.
`timescale 1ns/1ps

module tb_fdcpd_decode;
  localparam int SU = 4;  // Short step unit keeps seeks brief
  localparam int PE = 3;
  logic mclk = 1'b0, srst = 1'b1, cmdLoad = '0, multiTrackFlag = '0;
  logic skipFlag = '0, nonDmaFlag = '0, headAddr = '0;
  logic enableCountBit = '0, stepInward = '0, overwriteFlag = '0;
  logic pollingDisable = '0, writeGateSetting = '0, writeGateReq = '0;
  logic statusLoad = '0, resultRead = '0;
  logic [3:0] cmdOp = '0, stepRateField = '0, perpDriveBits = '0;
  logic [7:0] sizeCode = '0, sectorAddr = '0, specialSectorLength = '0;
  logic [7:0] sectorsPerTrackField = '0, newCylinderField = '0;
  logic [7:0] relativeCylinderOffset = '0, precompStartTrack = '0;
  logic [7:0] statusRegZero = '0, statusRegOne = '0, statusRegTwo = '0;
  logic [7:0] statusRegThree = '0, lastSector = '0, delMask = '0;
  logic sectorDone, sectorDeleted, endOfTrack, byteXfer, cmdReject;
  logic xferActive, seekActive, resultPhase, opDone, curHead;
  logic sectorPass, sectorSkip, xferIrq, dmaReq, stepPulse, stepDir;
  logic pollEnable, precompActive, writeEnable, writeDataOk;
  logic [7:0] curSector, presentCylinder, resultByte;
  logic [14:0] sectorBytes, hostBytes;
  logic [3:0] perpDrives;
  logic [7:0] trk [4] = '{8'h00, 8'h05, 8'h06, 8'hFF};
  int n_errors = 0, check_count = 0, cyc = 0, lastStep = 0, gap = 0;
  int nPass, nSkip, nIrq, nDma;

  fdcpd_decode #(.STEP_UNIT_CYC(SU), .PREERASE_CYC(PE)) u_fdcpd_decode (.*);
  fdcpd_disk_model u_fdcpd_disk_model (.*);

  always #5 mclk = ~mclk;

  // Event tallies, sampled where the pulses are settled
  always @(posedge mclk) begin
    cyc++;
    if (sectorPass) nPass++;
    if (sectorSkip) nSkip++;
    if (xferIrq) nIrq++;
    if (dmaReq) nDma++;
    if (stepPulse) begin
      gap = cyc - lastStep;
      lastStep = cyc;
    end
  end

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Every task starts and ends just after an edge
  task automatic cmd(input logic [3:0] op);
    @(posedge mclk);
    #1 cmdOp = op;
    cmdLoad = 1'b1;
    @(posedge mclk);
    #1 cmdLoad = 1'b0;
  endtask : cmd

  task automatic waitDone();
    for (int k = 0; k < 500 && opDone !== 1'b1; k++) begin
      @(posedge mclk);
      #1;
    end
    chk("opDone", 16'h0001, 16'(opDone));
    @(posedge mclk);
    #1;
  endtask : waitDone

  task automatic run(input logic [3:0] op, input logic [2:0] f,
                     input logic [7:0] a, b, input int p, s);
    {multiTrackFlag, skipFlag, nonDmaFlag} = f;
    sectorAddr = a;
    lastSector = b;
    {nPass, nSkip, nIrq, nDma} = '0;
    cmd(op);
    waitDone();
    chk("passed", 16'(p), 16'(nPass));
    chk("skipped", 16'(s), 16'(nSkip));
    chk("requests", 16'(p + s), 16'(nonDmaFlag ? nIrq : nDma));
    chk("wrongKind", 16'h0000, 16'(nonDmaFlag ? nDma : nIrq));
  endtask : run

  task automatic seek(input logic [3:0] op, input logic [7:0] c, input int g);
    cmd(op);
    waitDone();
    chk("cylinder", 16'(c), 16'(presentCylinder));
    chk("stepGap", 16'(g), 16'(gap));
  endtask : seek

  task automatic rd(input logic [7:0] e);
    chk("resultByte", 16'(e), 16'(resultByte));
    @(posedge mclk);
    #1 resultRead = 1'b1;
    @(posedge mclk);
    #1 resultRead = 1'b0;
  endtask : rd

  // Lock sets the overwrite gate, then perpendicular mode and write gate
  task automatic perp(input logic ow, input logic [3:0] e, input int w);
    int c;
    overwriteFlag = ow;
    cmd(fdcpd_pkg::OP_LOCK);
    writeGateSetting = ~ow;
    perpDriveBits = 4'h5;
    cmd(fdcpd_pkg::OP_PERP);
    chk("perpDrives", 16'(e), 16'(perpDrives));
    @(posedge mclk);
    #1 writeGateReq = 1'b1;
    for (c = 0; c < 50 && writeDataOk !== 1'b1; c++) begin
      @(posedge mclk);
      #1;
    end
    chk("dataDelay", 16'(w), 16'(c));
    writeGateReq = 1'b0;
    @(posedge mclk);
    #1 chk("dataOff", 16'h0000, 16'(writeDataOk));
  endtask : perp

  task automatic complete_run();
    if (n_errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run

  // Hang guard, far beyond the few hundred cycles needed
  initial begin
    #500000;
    n_errors++;
    complete_run();
  end

  // Main sequence
  initial begin
    repeat (3) @(posedge mclk);
    #1 srst = 1'b0;
    chk("curSector", 16'h0001, 16'(curSector));
    chk("hostBytes", 16'h0080, 16'(hostBytes));
    chk("pollEnable", 16'h0001, 16'(pollEnable));
    // Every size code, with a busy refusal in mid-transfer
    for (int n = 0; n < 8; n++) begin
      sizeCode = 8'(n);
      specialSectorLength = n == 0 ? 8'h40 : 8'hFF;
      sectorAddr = 8'h02;
      lastSector = 8'h02;
      cmd(fdcpd_pkg::OP_READ);
      chk("curSector", 16'h0002, 16'(curSector));
      chk("sectorBytes", 16'h0080 << n, 16'(sectorBytes));
      chk("hostBytes", n == 0 ? 16'h0040 : 16'h0080 << n,
          16'(hostBytes));
      cmd(fdcpd_pkg::OP_WRITE);
      chk("busyReject", 16'h0001, 16'(cmdReject));
      waitDone();
    end
    sizeCode = 8'h08;
    cmd(fdcpd_pkg::OP_READ);
    chk("sizeReject", 16'h0001, 16'(cmdReject));
    sizeCode = 8'h02;  // A size the modelled drive supports
    delMask = 8'h04;
    run(fdcpd_pkg::OP_READ, 3'h3, 8'h01, 8'h04, 3, 1);
    run(fdcpd_pkg::OP_READ_DEL, 3'h2, 8'h01, 8'h04, 1, 3);
    run(fdcpd_pkg::OP_READ, 3'h1, 8'h01, 8'h04, 4, 0);
    run(fdcpd_pkg::OP_WRITE, 3'h0, 8'h01, 8'h04, 4, 0);
    delMask = 8'h00;
    run(fdcpd_pkg::OP_READ, 3'h4, 8'h01, 8'h02, 4, 0);
    chk("curHead", 16'h0001, 16'(curHead));
    sectorsPerTrackField = 8'h03;
    run(fdcpd_pkg::OP_FORMAT, 3'h0, 8'h01, 8'hFF, 3, 0);
    enableCountBit = 1'b1;
    specialSectorLength = 8'h02;
    run(fdcpd_pkg::OP_VERIFY, 3'h0, 8'h01, 8'hFF, 2, 0);
    // Seeks at the fastest and next step rate
    newCylinderField = 8'h03;
    stepRateField = 4'hF;
    seek(fdcpd_pkg::OP_SEEK, 8'h03, SU);
    relativeCylinderOffset = 8'h02;
    stepInward = 1'b1;
    stepRateField = 4'hE;
    seek(fdcpd_pkg::OP_REL_SEEK, 8'h05, 2 * SU);
    // Threshold at both ends of the track range, head on cylinder 05
    for (int i = 0; i < 4; i++) begin
      precompStartTrack = trk[i];
      cmd(fdcpd_pkg::OP_CONFIGURE);
      chk("precomp", 16'(i < 2), 16'(precompActive));
    end
    perp(1'b0, 4'h0, PE + 1);
    perp(1'b1, 4'h5, 1);
    {statusRegZero, statusRegOne, statusRegTwo, statusRegThree} = 32'hA1B2C3D4;
    @(posedge mclk);
    #1 statusLoad = 1'b1;
    @(posedge mclk);
    #1 statusLoad = 1'b0;
    rd(8'hA1);
    rd(8'hB2);
    rd(8'hC3);
    rd(8'hD4);
    @(posedge mclk);
    #1 chk("resultPhase", 16'h0000, 16'(resultPhase));
    cmd(fdcpd_pkg::OP_SENSE_INT);
    rd(8'hA1);
    rd(8'h05);
    @(posedge mclk);
    #1 chk("resultPhase", 16'h0000, 16'(resultPhase));
    pollingDisable = 1'b1;
    @(posedge mclk);
    #1 chk("pollEnable", 16'h0000, 16'(pollEnable));
    pollingDisable = 1'b0;
    @(posedge mclk);
    #1 chk("pollEnable", 16'h0001, 16'(pollEnable));
    complete_run();
  end
endmodule : tb_fdcpd_decode
